/* core/sacp_consts.svh */
`ifndef SACP_CONSTS_SVH
`define SACP_CONSTS_SVH

`define SACP_RES_BITS       12
`define SACP_CODE_STEPS     4096
`define SACP_CONV_PERIODS   28
`define SACP_CONV_MIN       26
`define SACP_RESULT_RESET   12'h000
`define SACP_PER_W          5

`endif

/* core/sacp_pkg.sv */
package sacp_pkg;
    typedef logic [11:0] sacp_code_t;

    // Host read strobes grouped as they travel together on the bus.
    typedef struct packed {
        logic cs_n;
        logic rd_n;
    } sacp_host_t;

    // Three-state result bus: value plus enable.
    typedef struct packed {
        sacp_code_t data;
        logic       oe;
    } sacp_bus_t;

    typedef enum logic [1:0] {
        SACP_IDLE,
        SACP_CONVERT,
        SACP_DONE
    } sacp_state_t;
endpackage

/* core/sacp_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of asynchronous pins.
module sacp_sync #(
    parameter int W = 1
) (
    input  wire logic         I_CORE_CLK,
    input  wire logic         I_RESET,
    input  wire logic [W-1:0] i_async,
    input  wire logic [W-1:0] i_reset_val,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // The first stage feeds only the second stage; reset values are constants per bit.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
                if (I_RESET) begin
                    meta_q[g] <= 1'b1;
                    sync_q[g] <= 1'b1;
                end else begin
                    meta_q[g] <= i_async[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_q;
endmodule // sacp_sync

/* core/sacp_ctrl.sv */
`timescale 1ns/1ps
`include "sacp_consts.svh"
// Conversion sequencer and host read port of the sampling converter.
// The conversion clock arrives as a pin and is sampled; each rising edge of it is one period.
module sacp_ctrl (
    input  wire logic                I_CORE_CLK,
    input  wire logic                I_RESET,
    input  wire logic                I_CONVERT_START,
    input  wire logic                I_CONVERSION_CLOCK,
    input  wire logic                I_CS_N,
    input  wire logic                I_RD_N,
    input  wire logic                I_MODE,
    input  wire logic                I_COMPARATOR,
    output logic                     O_BUSY_N,
    output logic                     O_HOLD,
    output logic                     O_POWER_SAVE,
    output logic                     O_DAC_VALID,
    output sacp_pkg::sacp_code_t     O_DAC_CODE,
    output sacp_pkg::sacp_code_t     O_RESULT_BUS,
    output logic                     O_RESULT_BUS_OE
);
    import sacp_pkg::*;

    // Pin group order: convert_start, conversion_clock, cs_n, rd_n, mode.
    logic [4:0]  pins_async;
    logic [4:0]  pins_sync;
    logic        start_s;
    logic        cclk_s;
    logic        mode_s;
    sacp_host_t  host_s;

    assign pins_async = {I_CONVERT_START, I_CONVERSION_CLOCK, I_CS_N, I_RD_N, I_MODE};

    // The five control pins are asynchronous to the core clock and pass two flops; the comparator input is used unsynchronised.
    sacp_sync #(
        .W (5)
    ) u_sync (
        .I_CORE_CLK  (I_CORE_CLK),
        .I_RESET     (I_RESET),
        .i_async     (pins_async),
        .i_reset_val (5'h1f),
        .o_sync      (pins_sync)
    );

    assign start_s     = pins_sync[4];
    assign cclk_s      = pins_sync[3];
    assign host_s.cs_n = pins_sync[2];
    assign host_s.rd_n = pins_sync[1];
    assign mode_s      = pins_sync[0];

    // Selected only while chip select is low, and reading only with read low too.
    function automatic logic host_read(input sacp_host_t h);
        return (!h.cs_n) && (!h.rd_n);
    endfunction

    // Edge detectors look only at synchronised levels.
    logic start_prev_q;
    logic cclk_prev_q;
    logic start_rise;
    logic cclk_rise;

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            start_prev_q <= 1'b1;
            cclk_prev_q  <= 1'b1;
        end else begin
            start_prev_q <= start_s;
            cclk_prev_q  <= cclk_s;
        end
    end

    // The start edge ignores select and read entirely.
    assign start_rise = start_s && !start_prev_q;
    assign cclk_rise  = cclk_s && !cclk_prev_q;

    // Sequencer state.
    sacp_state_t               state_q;
    logic [`SACP_PER_W-1:0]    period_q;
    logic [3:0]                bit_q;
    sacp_code_t                sar_q;
    sacp_code_t                result_q;
    logic                      hold_q;

    // A conversion lasts a fixed 28 periods of the conversion clock; the
    // first two are spent settling the hold, then one period per bit
    // leaves margin so completion always lands inside 26 to 28 periods.
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_q <= SACP_IDLE;
        end else if (start_rise) begin
            state_q <= SACP_CONVERT;
        end else begin
            unique case (state_q)
                SACP_IDLE: begin
                    state_q <= SACP_IDLE;
                end
                SACP_CONVERT: begin
                    if (cclk_rise && period_q == 5'(`SACP_CONV_PERIODS - 1)) begin
                        state_q <= SACP_DONE;
                    end
                end
                SACP_DONE: begin
                    state_q <= SACP_DONE;
                end
            endcase
        end
    end

    // Period counter restarts on every start edge, so a restart mid-way
    // aborts the old conversion; the host is expected to avoid this.
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            period_q <= '0;
        end else if (start_rise) begin
            period_q <= '0;
        end else if (state_q == SACP_CONVERT && cclk_rise) begin
            period_q <= period_q + 5'h01;
        end
    end

    // Hold flag follows the conversion; tracking resumes when it ends.
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            hold_q <= 1'b0;
        end else if (start_rise) begin
            hold_q <= 1'b1;
        end else if (state_q != SACP_CONVERT) begin
            hold_q <= 1'b0;
        end
    end

    // Successive approximation: bits 11 down to 0 on periods 2 to 13.
    // Trial bit is set when a bit slot begins and kept or dropped by the
    // comparator one period later.
    logic bit_slot;
    assign bit_slot = (state_q == SACP_CONVERT) && cclk_rise
                      && (period_q >= 5'h02) && (period_q < 5'h0e);

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            bit_q <= 4'hb;
            sar_q <= `SACP_RESULT_RESET;
        end else if (start_rise) begin
            bit_q <= 4'hb;
            sar_q <= 12'h800;
        end else if (bit_slot) begin
            // Comparator high means the input lies below the trial code.
            if (I_COMPARATOR) begin
                sar_q[bit_q] <= 1'b0;
            end
            if (bit_q != 4'h0) begin
                sar_q[bit_q - 4'h1] <= 1'b1;
                bit_q <= bit_q - 4'h1;
            end
        end
    end

    // Result is latched once at completion and held until the next conversion completes.
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            result_q <= `SACP_RESULT_RESET;
        end else if (state_q == SACP_CONVERT && cclk_rise
                     && period_q == 5'(`SACP_CONV_PERIODS - 1)) begin
            result_q <= sar_q;
        end
    end

    // Bus output registers: data changes only when the latch does.
    sacp_bus_t bus_q;
    logic      converting;
    assign converting = (state_q == SACP_CONVERT);

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            bus_q <= '{data: `SACP_RESULT_RESET, oe: 1'b0};
        end else begin
            bus_q.data <= result_q;
            // Drivers are off during conversion and whenever select or read is high.
            bus_q.oe   <= host_read(host_s) && !converting && !start_rise;
        end
    end

    // Status goes low for the whole conversion and high at completion.
    logic busy_n_q;
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            busy_n_q <= 1'b1;
        end else begin
            busy_n_q <= !(converting || start_rise);
        end
    end

    // Power save is a level; it does not stop a conversion, only flags the analog side.
    logic psave_q;
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            psave_q <= 1'b0;
        end else begin
            psave_q <= !mode_s;
        end
    end

    // Outputs.
    assign O_BUSY_N        = busy_n_q;
    assign O_HOLD          = hold_q;
    assign O_POWER_SAVE    = psave_q;
    assign O_DAC_VALID     = converting;
    assign O_DAC_CODE      = sar_q;
    assign O_RESULT_BUS    = bus_q.data;
    assign O_RESULT_BUS_OE = bus_q.oe;
endmodule // sacp_ctrl

/* sim/sacp_cmp_model.sv */
`timescale 1ns/1ps
// Ideal comparator on the analog side; it reports a held input below the trial code.
module sacp_cmp_model (
    input  wire logic                 i_dac_valid,
    input  wire sacp_pkg::sacp_code_t i_dac_code,
    input  wire sacp_pkg::sacp_code_t i_vin,
    output logic                      o_comp
);
    import sacp_pkg::*;
    // Outside a conversion nothing is compared, so the output idles low.
    assign o_comp = i_dac_valid ? (i_vin < i_dac_code) : 1'b0;
endmodule // sacp_cmp_model

/* sim/sacp_ctrl_sva.sv */
`timescale 1ns/1ps
// Pin-level checks of the converter control; a period is 20 core cycles here.
module sacp_ctrl_sva (
    input wire logic                 I_CORE_CLK,
    input wire logic                 I_RESET,
    input wire logic                 I_CONVERT_START,
    input wire logic                 I_CS_N,
    input wire logic                 I_RD_N,
    input wire logic                 I_MODE,
    input wire logic                 O_BUSY_N,
    input wire logic                 O_HOLD,
    input wire logic                 O_POWER_SAVE,
    input wire sacp_pkg::sacp_code_t O_RESULT_BUS,
    input wire logic                 O_RESULT_BUS_OE
);
    import sacp_pkg::*;
    localparam int LO_MIN = 520;
    localparam int LO_MAX = 570;
    logic [9:0] lo_q;
    // Length of the busy period; the margin covers the pin synchronisers.
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) lo_q <= 10'h000;
        else lo_q <= O_BUSY_N ? 10'h000 : lo_q + 10'h001;
    end
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    sequence s_read_seen;
        $past(I_CS_N, 3) == 1'b0 && $past(I_RD_N, 3) == 1'b0;
    endsequence
    sequence s_idle;
        O_BUSY_N && $past(O_BUSY_N) && $past(O_BUSY_N, 2) && $past(O_BUSY_N, 3);
    endsequence
    a_start_busy: assert property ($rose(I_CONVERT_START) |-> ##[1:4] !O_BUSY_N)
        else $error("busy did not fall after start");
    a_hold_busy: assert property (O_HOLD == !O_BUSY_N) else $error("hold and busy disagree");
    a_bus_quiet: assert property (!O_BUSY_N && $past(!O_BUSY_N) |-> !O_RESULT_BUS_OE)
        else $error("bus driven in conversion");
    a_read_gate: assert property (O_RESULT_BUS_OE |-> s_read_seen) else $error("bus driven unselected");
    a_read_drive: assert property (s_read_seen and s_idle |-> O_RESULT_BUS_OE)
        else $error("bus not driven on read");
    a_data_hold: assert property (O_RESULT_BUS_OE && $past(O_RESULT_BUS_OE) |-> $stable(O_RESULT_BUS))
        else $error("result changed while read");
    a_conv_bound: assert property ($fell(O_BUSY_N) |-> ##[1:LO_MAX] O_BUSY_N) else $error("conversion hangs");
    a_conv_len: assert property ($rose(O_BUSY_N) |-> lo_q >= LO_MIN && lo_q <= LO_MAX)
        else $error("conversion length wrong");
    a_mode_save: assert property (O_POWER_SAVE == !$past(I_MODE, 3)) else $error("power save wrong");
endmodule // sacp_ctrl_sva

bind sacp_ctrl sacp_ctrl_sva u_sva (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .I_CONVERT_START(I_CONVERT_START),
    .I_CS_N(I_CS_N), .I_RD_N(I_RD_N), .I_MODE(I_MODE), .O_BUSY_N(O_BUSY_N), .O_HOLD(O_HOLD),
    .O_POWER_SAVE(O_POWER_SAVE), .O_RESULT_BUS(O_RESULT_BUS), .O_RESULT_BUS_OE(O_RESULT_BUS_OE));

/* sim/tb.sv */
`timescale 1ns/1ps
// Host-side bench: starts conversions, reads the result bus and toggles the mode pin.
module tb;
    import sacp_pkg::*;
    logic       clk, rst, start, cclk, cs_n, rd_n, mode, comp, busy_n, hold, psave, dvalid, oe;
    sacp_code_t dcode, bus, vin;
    logic [4:0] cdiv;
    int         failures, comparisons, lo;
    sacp_code_t codes [5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'ha5c};
    sacp_cmp_model u_cmp (.i_dac_valid(dvalid), .i_dac_code(dcode), .i_vin(vin), .o_comp(comp));
    sacp_ctrl u_dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_CONVERT_START(start), .I_CONVERSION_CLOCK(cclk),
        .I_CS_N(cs_n), .I_RD_N(rd_n), .I_MODE(mode), .I_COMPARATOR(comp), .O_BUSY_N(busy_n), .O_HOLD(hold),
        .O_POWER_SAVE(psave), .O_DAC_VALID(dvalid), .O_DAC_CODE(dcode), .O_RESULT_BUS(bus), .O_RESULT_BUS_OE(oe));
    // Core clock of 10 ns.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Free-running conversion clock of 20 core cycles, kept short to bound the run.
    always @(posedge clk) begin
        cdiv <= (cdiv == 5'h13) ? 5'h00 : cdiv + 5'h01;
        cclk <= (cdiv < 5'h0a);
    end
    task automatic check(input sacp_code_t got, input sacp_code_t exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check({11'h000, got}, {11'h000, exp});
    endtask
    task automatic finish_test();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Starts one conversion and waits it out, plus an acquisition gap before the next.
    task automatic convert(input sacp_code_t v);
        @(posedge clk);
        vin <= v;
        start <= 1'b0;
        repeat (3) @(posedge clk);
        start <= 1'b1;
        lo = 0;
        while (busy_n !== 1'b0 && lo < 8) begin @(negedge clk); lo++; end
        repeat (50) @(negedge clk);
        check_bit(hold, 1'b1);
        check_bit(oe, 1'b0);
        lo = 50;
        while (busy_n !== 1'b1 && lo < 700) begin @(negedge clk); lo++; end
        check_bit(lo >= 520 && lo <= 570, 1'b1);
        repeat (300) @(negedge clk);
    endtask
    // One bus read held until the enable is seen, then released.
    task automatic read_bus(input sacp_code_t exp);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        lo = 0;
        while (oe !== 1'b1 && lo < 8) begin @(negedge clk); lo++; end
        check(bus, exp);
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (5) @(negedge clk);
        check_bit(oe, 1'b0);
    endtask
    // Main sequence.
    initial begin
        {rst, start, cs_n, rd_n, mode} = 5'h1f;
        {vin, cdiv, cclk, failures, comparisons} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check_bit(busy_n, 1'b1);
        check_bit(oe, 1'b0);
        check(bus, 12'h000);
        foreach (codes[i]) begin
            convert(codes[i]);
            read_bus(codes[i]);
            read_bus(codes[i]);
        end
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (6) @(negedge clk);
        check_bit(oe, 1'b0);
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b0;
        repeat (6) @(negedge clk);
        check_bit(oe, 1'b0);
        @(posedge clk);
        cs_n <= 1'b0;
        convert(12'h3c6);
        check_bit(oe, 1'b1);
        check(bus, 12'h3c6);
        @(posedge clk);
        {cs_n, rd_n, mode} <= 3'h6;
        repeat (4) @(negedge clk);
        check_bit(psave, 1'b1);
        @(posedge clk);
        mode <= 1'b1;
        repeat (4) @(negedge clk);
        check_bit(psave, 1'b0);
        finish_test();
    end
    // Watchdog well beyond the roughly 53 us that the sequence needs.
    initial begin
        #200000;
        failures++;
        finish_test();
    end
endmodule // tb
